// [src/rsw_pkg.sv]
package rsw_pkg;

  // ---------------------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS    = 10;
  // active-hold after the supply recovers; least time, so rounded up
  localparam int RST_ACTV_NS      = 1000;
  localparam int HOLD_CYCLES      = (RST_ACTV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_W           = 8;
  localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_CYCLES[HOLD_W-1:0];

  // ---------------------------------------------------------------------------
  // machine cycle
  // ---------------------------------------------------------------------------
  localparam int MC_W             = 3;
  localparam logic [MC_W-1:0] MC_BASE_LEN = 3'h4;

  // ---------------------------------------------------------------------------
  // watchdog
  // ---------------------------------------------------------------------------
  localparam int WDT_W            = 24;
  localparam logic [7:0]       KEY_DISABLE = 8'h55;
  localparam logic [WDT_W-1:0] WDT_CLEAR   = 24'h000000;
  localparam logic [WDT_W-1:0] WDT_ALL_ONE = 24'hffffff;
  localparam logic [15:0]      WDT_LOW_CLR = 16'h0000;
  localparam logic [15:0]      FETCH_VEC   = 16'h0000;

  // ---------------------------------------------------------------------------
  // register map: printed offsets are indices, byte address is four times
  // ---------------------------------------------------------------------------
  localparam int APB_AW           = 12;
  localparam logic [7:0] IDX_RELOAD  = 8'ha6;
  localparam logic [7:0] IDX_KEY     = 8'hae;
  localparam logic [7:0] IDX_PWR     = 8'hb0;
  localparam logic [7:0] IDX_IRQ_ST  = 8'hb1;
  localparam logic [7:0] IDX_IRQ_MSK = 8'hb2;
  localparam logic [7:0] IDX_COUNT   = 8'hb3;
  localparam logic [APB_AW-1:0] ADDR_RELOAD  = {2'h0, IDX_RELOAD, 2'h0};
  localparam logic [APB_AW-1:0] ADDR_KEY     = {2'h0, IDX_KEY, 2'h0};
  localparam logic [APB_AW-1:0] ADDR_PWR     = {2'h0, IDX_PWR, 2'h0};
  localparam logic [APB_AW-1:0] ADDR_IRQ_ST  = {2'h0, IDX_IRQ_ST, 2'h0};
  localparam logic [APB_AW-1:0] ADDR_IRQ_MSK = {2'h0, IDX_IRQ_MSK, 2'h0};
  localparam logic [APB_AW-1:0] ADDR_COUNT   = {2'h0, IDX_COUNT, 2'h0};

  // field positions
  localparam int PWR_POR_BIT      = 0;
  localparam int EV_W             = 3;
  localparam int EV_WDT_BIT       = 0;
  localparam int EV_LVD_BIT       = 1;
  localparam int EV_DBG_BIT       = 2;
  localparam logic [EV_W-1:0] EV_RESET = 3'h0;

  typedef enum logic [1:0] {
    MC_RUN,
    MC_STALL
  } mc_state_e;

endpackage

// [src/reset_supervisor_watchdog.sv]
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps

module reset_supervisor_watchdog
  import rsw_pkg::*;
(
  // clock and reset
  input  wire logic              i_core_clk,
  input  wire logic              i_rst_n,
  // reset sources
  input  wire logic              i_ext_rst_n,
  input  wire logic              i_low_voltage_detector,
  input  wire logic              i_dbg_rst,
  // processor state
  input  wire logic              i_idle,
  input  wire logic              i_power_down,
  input  wire logic              i_mem_xfer,
  input  wire logic [MC_W-1:0]   i_bus_config_len,
  input  wire logic              i_stall,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // reset and interrupt outputs
  output logic                   o_core_rst,
  output logic                   o_pl_rst_n,
  output logic [15:0]            o_fetch_addr,
  output logic                   o_irq
);

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  function automatic logic is_mapped(input logic [APB_AW-1:0] a);
    is_mapped = (a == ADDR_RELOAD) || (a == ADDR_KEY) || (a == ADDR_PWR) ||
                (a == ADDR_IRQ_ST) || (a == ADDR_IRQ_MSK) || (a == ADDR_COUNT);
  endfunction

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  logic [31:0]       prdata_q;
  logic              pready_q;
  logic              pslverr_q;
  logic              core_rst_q;
  logic              pl_rst_n_q;
  logic [15:0]       fetch_q;
  logic              irq_q;
  logic [HOLD_W-1:0] hold_q;
  logic              wdt_to_q;
  logic [7:0]        key_q;
  logic [WDT_W-1:0]  cnt_q;
  logic              por_q;
  logic [EV_W-1:0]   irq_st_q;
  logic [EV_W-1:0]   irq_msk_q;
  logic              lvd_prev_q;
  logic              dbg_prev_q;
  logic [MC_W-1:0]   mc_cnt_q;
  mc_state_e         mc_state_q;
  logic              mc_tick_q;

  logic              acc;
  logic              wr_en;
  logic              wr_key;
  logic              wr_reload;
  logic              wdt_en;
  logic              wdt_run;
  logic              overflow;
  logic              src_any;
  logic [MC_W-1:0]   mc_len;
  logic [EV_W-1:0]   ev_set;
  logic [EV_W-1:0]   w1c;

  assign acc       = psel && penable && pready_q;
  assign wr_en     = acc && pwrite;
  assign wr_key    = wr_en && (paddr == ADDR_KEY);
  assign wr_reload = wr_en && (paddr == ADDR_RELOAD);
  assign wdt_en    = (key_q != KEY_DISABLE);
  assign wdt_run   = wdt_en && mc_tick_q && !i_idle && !i_power_down;
  assign overflow  = wdt_run && (cnt_q == WDT_ALL_ONE) && !wr_reload;

  // ---------------------------------------------------------------------------
  // apb slave: ready in the access phase, no wait states
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= psel && !penable;
      pslverr_q <= psel && !penable && !is_mapped(paddr);
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      prdata_q <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      // write-only key and reload read back as zero
      case (paddr)
        ADDR_PWR:     prdata_q <= {31'h0, por_q};
        ADDR_IRQ_ST:  prdata_q <= {29'h0, irq_st_q};
        ADDR_IRQ_MSK: prdata_q <= {29'h0, irq_msk_q};
        ADDR_COUNT:   prdata_q <= {8'h0, cnt_q};
        default:      prdata_q <= 32'h0;
      endcase
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  // ---------------------------------------------------------------------------
  // reset merge
  // ---------------------------------------------------------------------------
  // no control bit gates the low-voltage or debug sources, in any power mode
  assign src_any = !i_ext_rst_n || i_low_voltage_detector || i_dbg_rst ||
                   wdt_to_q || (hold_q != '0);

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      hold_q <= HOLD_LOAD;
    end else if (i_low_voltage_detector || wdt_to_q) begin
      hold_q <= HOLD_LOAD;
    end else if (hold_q != '0) begin
      hold_q <= hold_q - 1'b1;
    end
  end

  // registered merge keeps the release clean and synchronous
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      core_rst_q <= 1'b1;
      pl_rst_n_q <= 1'b0;
    end else begin
      core_rst_q <= src_any;
      pl_rst_n_q <= !src_any;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      fetch_q <= FETCH_VEC;
    end else if (core_rst_q) begin
      fetch_q <= FETCH_VEC;
    end
  end

  assign o_core_rst   = core_rst_q;
  assign o_pl_rst_n   = pl_rst_n_q;
  assign o_fetch_addr = fetch_q;

  // ---------------------------------------------------------------------------
  // power-on flag: set wins over the software clear
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      por_q <= 1'b0;
    end else if (i_low_voltage_detector) begin
      por_q <= 1'b1;
    end else if (wr_en && (paddr == ADDR_PWR) && pwdata[PWR_POR_BIT]) begin
      por_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // machine cycle timing
  // ---------------------------------------------------------------------------
  assign mc_len = (i_mem_xfer && (i_bus_config_len > MC_BASE_LEN)) ?
                  i_bus_config_len : MC_BASE_LEN;

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || core_rst_q) begin
      mc_cnt_q   <= '0;
      mc_state_q <= MC_RUN;
      mc_tick_q  <= 1'b0;
    end else begin
      mc_tick_q <= 1'b0;
      case (mc_state_q)
        MC_RUN: begin
          if (mc_cnt_q >= mc_len - 1'b1) begin
            if (i_stall) begin
              mc_state_q <= MC_STALL;
            end else begin
              mc_cnt_q  <= '0;
              mc_tick_q <= 1'b1;
            end
          end else begin
            mc_cnt_q <= mc_cnt_q + 1'b1;
          end
        end
        MC_STALL: begin
          // the cycle ends only once the stall is removed
          if (!i_stall) begin
            mc_state_q <= MC_RUN;
            mc_cnt_q   <= '0;
            mc_tick_q  <= 1'b1;
          end
        end
        default: begin
          mc_state_q <= MC_RUN;
          mc_cnt_q   <= '0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // watchdog key and counter
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || core_rst_q) begin
      key_q <= KEY_DISABLE;
    end else if (overflow) begin
      key_q <= KEY_DISABLE;
    end else if (wr_key) begin
      key_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || core_rst_q) begin
      cnt_q <= WDT_CLEAR;
    end else if (wr_reload) begin
      cnt_q <= {pwdata[7:0], WDT_LOW_CLR};
    end else if (wdt_run) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      wdt_to_q <= 1'b0;
    end else begin
      wdt_to_q <= overflow;
    end
  end

  // ---------------------------------------------------------------------------
  // interrupts: sticky, write one to clear, set wins
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      lvd_prev_q <= 1'b0;
      dbg_prev_q <= 1'b0;
    end else begin
      lvd_prev_q <= i_low_voltage_detector;
      dbg_prev_q <= i_dbg_rst;
    end
  end

  always_comb begin
    ev_set             = EV_RESET;
    ev_set[EV_WDT_BIT] = overflow;
    ev_set[EV_LVD_BIT] = i_low_voltage_detector && !lvd_prev_q;
    ev_set[EV_DBG_BIT] = i_dbg_rst && !dbg_prev_q;
    w1c                = (wr_en && (paddr == ADDR_IRQ_ST)) ? pwdata[EV_W-1:0] : EV_RESET;
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      irq_st_q <= EV_RESET;
    end else begin
      irq_st_q <= (irq_st_q & ~w1c) | ev_set;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      irq_msk_q <= EV_RESET;
    end else if (wr_en && (paddr == ADDR_IRQ_MSK)) begin
      irq_msk_q <= pwdata[EV_W-1:0];
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(((irq_st_q & ~w1c) | ev_set) & irq_msk_q);
    end
  end

  assign o_irq = irq_q;

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  a_ext_pin_rst: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    !i_ext_rst_n |=> o_core_rst)
    else $error("pin reset did not reach core reset");

  a_pin_no_stretch: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_ext_rst_n && !i_low_voltage_detector && !i_dbg_rst && !wdt_to_q && hold_q == '0)
    |=> !o_core_rst)
    else $error("core reset stretched with no source");

  a_pl_rst_pair: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    o_pl_rst_n == !o_core_rst)
    else $error("logic module reset out of step");

  a_lvd_hold_time: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    $fell(i_low_voltage_detector) |=> o_core_rst [*8])
    else $error("core reset released too soon after supply recovery");

  a_por_flag_set: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    i_low_voltage_detector |=> por_q)
    else $error("power-on flag not set");

  a_key_after_rst: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    o_core_rst |=> (key_q == KEY_DISABLE) && (cnt_q == WDT_CLEAR))
    else $error("key or counter not restored by reset");

  a_wdt_frozen_idle: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (!o_core_rst && !wr_reload && (i_idle || i_power_down)) |=> $stable(cnt_q))
    else $error("watchdog counted in low-power mode");

  a_reload_load: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (wr_reload && !o_core_rst) |=> cnt_q == {$past(pwdata[7:0]), WDT_LOW_CLR})
    else $error("reload did not set counter");

  a_overflow_rst: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    overflow |=> (key_q == KEY_DISABLE) ##1 o_core_rst)
    else $error("overflow did not disable and reset");

  a_mc_spacing: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    mc_tick_q |=> !mc_tick_q [*3])
    else $error("machine cycle shorter than four clocks");

  a_key_disables: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (key_q == KEY_DISABLE && !wr_reload && !o_core_rst) |=> $stable(cnt_q))
    else $error("disabled watchdog counted");

  a_dbg_rst_any: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    i_dbg_rst |=> o_core_rst)
    else $error("debug command did not reach core reset");

  a_lvd_rst_any: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    i_low_voltage_detector |=> o_core_rst)
    else $error("low supply did not reach core reset");

  a_fetch_vector: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    o_core_rst |=> (o_fetch_addr == FETCH_VEC))
    else $error("fetch address not at reset vector");

  a_wdt_step_one: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (wdt_run && !wr_reload && !o_core_rst) |=> (cnt_q == $past(cnt_q) + 24'h1))
    else $error("watchdog did not step by one");

  a_stall_holds: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (mc_state_q == MC_STALL && i_stall && !o_core_rst) |=> !mc_tick_q)
    else $error("machine cycle ended during stall");

  c_wdt_timeout:  cover property (@(posedge i_core_clk) disable iff (!i_rst_n) overflow);
  c_lvd_recover:  cover property (@(posedge i_core_clk) disable iff (!i_rst_n)
    $fell(i_low_voltage_detector));
  c_stall_cycle:  cover property (@(posedge i_core_clk) disable iff (!i_rst_n)
    mc_state_q == MC_STALL ##1 mc_tick_q);
  c_irq_raised:   cover property (@(posedge i_core_clk) disable iff (!i_rst_n) $rose(o_irq));

endmodule

// [bench/rsw_far_side.sv]
`timescale 1ns/1ps

// -----------------------------------------------
// far side: reset switch, debug port, supply, cpu
// -----------------------------------------------
module rsw_far_side
  import rsw_pkg::*;
(
  // clock
  input  wire logic       i_core_clk,
  // reset sources
  output logic            o_ext_rst_n,
  output logic            o_low_voltage,
  output logic            o_dbg_rst,
  // processor state
  output logic            o_idle,
  output logic            o_power_down,
  output logic            o_mem_xfer,
  output logic [MC_W-1:0] o_bus_len,
  output logic            o_stall
);
  initial begin
    o_ext_rst_n   = 1'b1;
    o_low_voltage = 1'b0;
    o_dbg_rst     = 1'b0;
    o_idle        = 1'b0;
    o_power_down  = 1'b0;
    o_mem_xfer    = 1'b0;
    o_bus_len     = MC_BASE_LEN;
    o_stall       = 1'b0;
  end

  // src 0 pin, 1 supply sag, else debug command; held n edges
  task automatic fire(input int src, input int n);
    @(posedge i_core_clk);
    case (src)
      0: o_ext_rst_n <= 1'b0;
      1: o_low_voltage <= 1'b1;
      default: o_dbg_rst <= 1'b1;
    endcase
    repeat (n) @(posedge i_core_clk);
    o_ext_rst_n   <= 1'b1;
    o_low_voltage <= 1'b0;
    o_dbg_rst     <= 1'b0;
  endtask

  task automatic mode(input logic idl, pd, mem, input logic [MC_W-1:0] len, input logic st);
    @(posedge i_core_clk);
    o_idle       <= idl;
    o_power_down <= pd;
    o_mem_xfer   <= mem;
    o_bus_len    <= len;
    o_stall      <= st;
  endtask
endmodule

// [bench/tb_top.sv]
`timescale 1ns/1ps

module tb_top;
  import rsw_pkg::*;
  logic              clk;
  logic              rst_n;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [APB_AW-1:0] paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              core_rst;
  logic              pl_rst_n;
  logic              irq;
  logic [15:0]       fetch;
  wire               ext_n;
  wire               low_voltage_detector;
  wire               dbg;
  wire               idle;
  wire               pd;
  wire               mem;
  wire               st;
  wire  [MC_W-1:0]   blen;
  logic [31:0]       r;
  logic              e;
  int                num_errors = 0;
  int                check_count = 0;
  int                cyc = 0;
  int                stamp;
  int                n;
  int                d;
  int                x;

  always #5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  rsw_far_side far (.i_core_clk(clk), .o_ext_rst_n(ext_n), .o_low_voltage(low_voltage_detector),
    .o_dbg_rst(dbg), .o_idle(idle), .o_power_down(pd), .o_mem_xfer(mem),
    .o_bus_len(blen), .o_stall(st));

  reset_supervisor_watchdog uut (.i_core_clk(clk), .i_rst_n(rst_n), .i_ext_rst_n(ext_n),
    .i_low_voltage_detector(low_voltage_detector), .i_dbg_rst(dbg), .i_idle(idle), .i_power_down(pd),
    .i_mem_xfer(mem), .i_bus_config_len(blen), .i_stall(st), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .o_core_rst(core_rst),
    .o_pl_rst_n(pl_rst_n), .o_fetch_addr(fetch), .o_irq(irq));

  task automatic tally_and_finish();
    if (num_errors == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", nm, exp, got);
      num_errors++;
    end
  endtask

  // request held until the rising edge that samples pready high; data taken at that edge
  task automatic apb(input logic w, input logic [APB_AW-1:0] a, input logic [31:0] dat);
    int k;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= dat;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      num_errors++;
      tally_and_finish();
    end
    r = prdata;
    e = pslverr;
    stamp = cyc;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_core(input logic lvl, output int cnt);
    cnt = 0;
    do begin
      @(negedge clk);
      cnt++;
      chk("pl reset", {31'h0, pl_rst_n}, {31'h0, ~core_rst});
    end while (core_rst !== lvl && cnt < 400);
    if (cnt >= 400) begin
      num_errors++;
      tally_and_finish();
    end
  endtask

  // counter advance over a fixed gap, and the advance expected at len clocks a tick
  task automatic rate(input int len, output int dd, output int ee);
    int t0;
    logic [31:0] c0;
    apb(1'b0, ADDR_COUNT, 32'h0);
    c0 = r;
    t0 = stamp;
    repeat (40) @(posedge clk);
    apb(1'b0, ADDR_COUNT, 32'h0);
    dd = int'(r - c0);
    ee = (stamp - t0) / len;
  endtask

  // -----------------------------------------------
  // main sequence
  // -----------------------------------------------
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    wait_core(1'b0, n);
    chk("fetch vector", {16'h0, fetch}, {16'h0, FETCH_VEC});
    apb(1'b0, 12'h000, 32'h0);
    chk("unmapped err", {31'h0, e}, 32'h1);
    chk("unmapped data", r, 32'h0);
    apb(1'b0, ADDR_IRQ_MSK, 32'h0);
    chk("mask reset", r, 32'h0);
    // supply sag and debug command while asleep: neither source may be gated
    far.mode(1'b1, 1'b1, 1'b0, MC_BASE_LEN, 1'b0);
    far.fire(1, 3);
    wait_core(1'b0, n);
    chk("supply hold", n >= HOLD_CYCLES && n <= HOLD_CYCLES + 3, 32'h1);
    far.fire(2, 3);
    wait_core(1'b0, n);
    chk("debug release", n, 32'h2);
    far.mode(1'b0, 1'b0, 1'b0, MC_BASE_LEN, 1'b0);
    far.fire(0, 5);
    wait_core(1'b0, n);
    chk("pin release", n, 32'h2);
    apb(1'b0, ADDR_PWR, 32'h0);
    chk("power flag set", {31'h0, r[PWR_POR_BIT]}, 32'h1);
    apb(1'b1, ADDR_PWR, 32'h1 << PWR_POR_BIT);
    apb(1'b0, ADDR_PWR, 32'h0);
    chk("power flag clear", {31'h0, r[PWR_POR_BIT]}, 32'h0);
    apb(1'b0, ADDR_IRQ_ST, 32'h0);
    chk("irq status", r, 32'h6);
    chk("irq masked", {31'h0, irq}, 32'h0);
    apb(1'b1, ADDR_IRQ_MSK, 32'h4);
    repeat (2) @(negedge clk);
    chk("irq raised", {31'h0, irq}, 32'h1);
    apb(1'b1, ADDR_IRQ_ST, 32'h4);
    repeat (2) @(negedge clk);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    apb(1'b0, ADDR_IRQ_ST, 32'h0);
    chk("status after clear", r, 32'h2);
    // watchdog
    apb(1'b0, ADDR_KEY, 32'h0);
    chk("key read", r, 32'h0);
    apb(1'b0, ADDR_COUNT, 32'h0);
    chk("count after reset", r, 32'h0);
    apb(1'b1, ADDR_KEY, 32'haa);
    apb(1'b1, ADDR_RELOAD, 32'hfe);
    apb(1'b0, ADDR_COUNT, 32'h0);
    chk("reload high", {24'h0, r[23:16]}, 32'hfe);
    chk("reload low", r[15:0] < 16'h10, 32'h1);
    rate(4, d, x);
    chk("tick rate", d >= x - 1 && d <= x + 1, 32'h1);
    far.mode(1'b0, 1'b0, 1'b1, 3'h6, 1'b0);
    rate(6, d, x);
    chk("bus tick rate", d >= x - 1 && d <= x + 1, 32'h1);
    far.mode(1'b0, 1'b0, 1'b0, MC_BASE_LEN, 1'b1);
    rate(4, d, x);
    chk("stall ticks", d <= 1, 32'h1);
    far.mode(1'b1, 1'b0, 1'b0, MC_BASE_LEN, 1'b0);
    rate(4, d, x);
    chk("idle freeze", d, 32'h0);
    far.mode(1'b0, 1'b1, 1'b0, MC_BASE_LEN, 1'b0);
    rate(4, d, x);
    chk("sleep freeze", d, 32'h0);
    far.mode(1'b0, 1'b0, 1'b0, MC_BASE_LEN, 1'b0);
    apb(1'b1, ADDR_KEY, 32'h55);
    rate(4, d, x);
    chk("key disable", d, 32'h0);
    // any reset must disarm a running watchdog
    apb(1'b1, ADDR_KEY, 32'h3c);
    far.fire(0, 2);
    wait_core(1'b0, n);
    rate(4, d, x);
    chk("count cleared", r, 32'h0);
    tally_and_finish();
  end
endmodule
